// [tod_pkg.sv]
// Constants and types for the transmission offset descriptor parser
// Function
// R1: Tag byte, length byte, length bounds consumption
// R2: Security descriptor: first body byte is type
// R3: Forward length minus one payload bytes in order
// R4: Offset descriptor: forward entry count byte first
// R5: Forward entry: satellite, centre id, 32-bit delay
// R6: Return count, then satellite, gateway, delay entries
// R7: Delay is network clock reference tick count
// R8: Forward delay centre-satellite, return satellite-gateway
// R9: Forward entry needs satellite and centre match
// R10: Return entry needs satellite and gateway match
// R11: Matched forward delay added when reference present
// R12: Transmission advanced earlier by forward delay
// R13: Matched return delay added to calculation
// R14: Both matched: correction is their sum
// R15: No descriptor or zero delays: no correction
// R16: MSB first; excess ignored; truncated descriptor discarded
package tod_pkg;
  localparam logic [7:0] TOD_TAG_SEC_DEF = 8'h00;
  localparam logic [7:0] TOD_TAG_OFS_DEF = 8'h01;
  localparam int         TOD_DELAY_W     = 32;
  localparam int         TOD_CORR_W      = 33;
  localparam logic [1:0] TOD_ENTRY_LAST  = 2'h3;
  localparam logic [7:0] TOD_ONE         = 8'h01;

  typedef enum logic [3:0] {
    TOD_IDLE  = 4'h0,
    TOD_LEN   = 4'h1,
    TOD_STYPE = 4'h3,
    TOD_SPAY  = 4'h2,
    TOD_FCNT  = 4'h6,
    TOD_FSAT  = 4'h7,
    TOD_FCC   = 4'h5,
    TOD_FDLY  = 4'h4,
    TOD_RCNT  = 4'hc,
    TOD_RSAT  = 4'hd,
    TOD_RGW   = 4'hf,
    TOD_RDLY  = 4'he,
    TOD_SKIP  = 4'ha
  } tod_state_t;

  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic [7:0] data;
  } tod_byte_t;

  typedef struct packed {
    logic [7:0] sat_id;
    logic [7:0] peer_id;
  } tod_pair_t;
endpackage

// [tod_delay_acc.sv]
// Most-significant-first delay assembler with entry match capture
`timescale 1ns/1ps
module tod_delay_acc
  import tod_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_clear,
  input  wire logic                   i_shift,
  input  wire logic [7:0]             i_byte,
  input  wire logic                   i_done,
  input  wire logic                   i_match,
  output logic                        o_hit,
  output logic [TOD_DELAY_W-1:0]      o_delay
);
  logic [TOD_DELAY_W-1:0] shift_q;

  // ----------------------------------------
  // Byte assembly
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      shift_q <= '0;
    end else if (i_shift) begin
      shift_q <= {shift_q[TOD_DELAY_W-9:0], i_byte}; // R16
    end
  end

  // ----------------------------------------
  // Match capture, first matching entry kept
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst || i_clear) begin
      o_hit   <= 1'b0;
      o_delay <= '0;
    end else if (i_done && i_match && !o_hit) begin
      o_hit   <= 1'b1;
      o_delay <= {shift_q[TOD_DELAY_W-9:0], i_byte}; // R7
    end
  end
endmodule

// [tod_parser.sv]
// Descriptor parser producing security stream and timing offset
`timescale 1ns/1ps
module tod_parser
  import tod_pkg::*;
#(
  parameter logic [7:0] TAG_SEC = TOD_TAG_SEC_DEF,
  parameter logic [7:0] TAG_OFS = TOD_TAG_OFS_DEF
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire tod_byte_t             i_in,
  input  wire tod_pair_t             i_fwd_sel,
  input  wire tod_pair_t             i_ret_sel,
  input  wire logic                  i_ref_present,
  output logic                       o_sec_valid,
  output logic                       o_sec_type_valid,
  output logic                       o_sec_last,
  output logic [7:0]                 o_sec_data,
  output logic                       o_sec_abort,
  output logic                       o_corr_valid,
  output logic [TOD_CORR_W-1:0]      o_corr,
  output logic [TOD_DELAY_W-1:0]     o_fwd_delay,
  output logic [TOD_DELAY_W-1:0]     o_ret_delay
);
  if (TAG_SEC == TAG_OFS) begin : g_tag_clash
    $error("tags must differ");
  end

  tod_state_t  state_q;
  logic [7:0]  rem_q;
  logic [7:0]  cnt_q;
  logic [1:0]  bsel_q;
  tod_pair_t   ent_q;
  logic        fhit, rhit;
  logic [TOD_DELAY_W-1:0] fdly, rdly;
  logic        b, body, endlen, trunc, fdone, rdone, ok_q, tag_ofs_q;

  assign b      = i_in.valid;
  assign body   = b && !i_in.first;
  assign endlen = (rem_q == TOD_ONE);
  assign trunc  = b && i_in.first && (state_q != TOD_IDLE);
  assign fdone  = b && (state_q == TOD_FDLY) && (bsel_q == TOD_ENTRY_LAST);
  assign rdone  = b && (state_q == TOD_RDLY) && (bsel_q == TOD_ENTRY_LAST);

  function automatic logic pair_eq(input tod_pair_t a, input tod_pair_t s);
    pair_eq = (a.sat_id == s.sat_id) && (a.peer_id == s.peer_id);
  endfunction

  function automatic logic is_sec(input tod_state_t s);
    is_sec = (s == TOD_SPAY) || (s == TOD_STYPE);
  endfunction

  // ----------------------------------------
  // Byte state machine
  // ----------------------------------------
  logic tag_sec_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q   <= TOD_IDLE;
      rem_q     <= '0;
      tag_sec_q <= 1'b0;
      tag_ofs_q <= 1'b0;
    end else if (b) begin
      if (i_in.first) begin
        state_q   <= TOD_LEN; // R1
        tag_sec_q <= (i_in.data == TAG_SEC);
        tag_ofs_q <= (i_in.data == TAG_OFS);
        if (i_in.data != TAG_SEC && i_in.data != TAG_OFS) state_q <= TOD_SKIP;
      end else begin
        if (state_q != TOD_LEN) rem_q <= rem_q - TOD_ONE;
        case (state_q)
          TOD_LEN: begin
            rem_q <= i_in.data; // R1
            if (i_in.data == '0) state_q <= TOD_IDLE;
            else if (tag_sec_q) state_q <= TOD_STYPE;
            else state_q <= TOD_FCNT;
          end
          TOD_STYPE: state_q <= endlen ? TOD_IDLE : TOD_SPAY; // R2
          TOD_SPAY:  if (endlen) state_q <= TOD_IDLE; // R3
          TOD_FCNT:  state_q <= endlen ? TOD_IDLE : (i_in.data == '0 ? TOD_RCNT : TOD_FSAT); // R4
          TOD_FSAT:  state_q <= endlen ? TOD_IDLE : TOD_FCC; // R5
          TOD_FCC:   state_q <= endlen ? TOD_IDLE : TOD_FDLY;
          TOD_FDLY:  if (endlen) state_q <= TOD_IDLE;
                     else if (bsel_q == TOD_ENTRY_LAST) state_q <= (cnt_q == TOD_ONE) ? TOD_RCNT : TOD_FSAT;
          TOD_RCNT:  state_q <= endlen ? TOD_IDLE : (i_in.data == '0 ? TOD_SKIP : TOD_RSAT); // R6
          TOD_RSAT:  state_q <= endlen ? TOD_IDLE : TOD_RGW;
          TOD_RGW:   state_q <= endlen ? TOD_IDLE : TOD_RDLY;
          TOD_RDLY:  if (endlen) state_q <= TOD_IDLE;
                     else if (bsel_q == TOD_ENTRY_LAST) state_q <= (cnt_q == TOD_ONE) ? TOD_SKIP : TOD_RSAT;
          TOD_SKIP:  if (endlen || i_in.last) state_q <= TOD_IDLE; // R16
          default:   state_q <= TOD_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Entry counter, byte select and ids
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q  <= '0;
      bsel_q <= '0;
      ent_q  <= '0;
    end else if (body) begin
      case (state_q)
        TOD_FCNT, TOD_RCNT: cnt_q <= i_in.data;
        TOD_FSAT, TOD_RSAT: begin
          ent_q.sat_id <= i_in.data;
          bsel_q       <= '0;
        end
        TOD_FCC, TOD_RGW: ent_q.peer_id <= i_in.data;
        TOD_FDLY, TOD_RDLY: begin
          bsel_q <= bsel_q + 2'h1;
          if (bsel_q == TOD_ENTRY_LAST) cnt_q <= cnt_q - TOD_ONE;
        end
        default: bsel_q <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Delay assembly for each link direction
  // ----------------------------------------
  logic new_ofs;
  assign new_ofs = b && (state_q == TOD_LEN) && !tag_sec_q;

  logic fmatch, rmatch, fshift, rshift;
  assign fmatch = pair_eq(ent_q, i_fwd_sel); // R9
  assign rmatch = pair_eq(ent_q, i_ret_sel); // R10
  assign fshift = b && (state_q == TOD_FDLY);
  assign rshift = b && (state_q == TOD_RDLY);

  tod_delay_acc u_fwd (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_clear (new_ofs),
    .i_shift (fshift),
    .i_byte  (i_in.data),
    .i_done  (fdone),
    .i_match (fmatch),
    .o_hit   (fhit),
    .o_delay (fdly)
  );

  tod_delay_acc u_ret (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_clear (new_ofs),
    .i_shift (rshift),
    .i_byte  (i_in.data),
    .i_done  (rdone),
    .i_match (rmatch),
    .o_hit   (rhit),
    .o_delay (rdly)
  );

  // ----------------------------------------
  // Completion check: full declared length seen
  // ----------------------------------------
  logic ofs_end;
  assign ofs_end = body && tag_ofs_q && (state_q != TOD_LEN) && (state_q != TOD_IDLE) && endlen;

  always_ff @(posedge i_clk) begin
    if (i_rst || new_ofs || trunc) begin
      ok_q <= 1'b0;
    end else if (ofs_end) begin
      ok_q <= 1'b1; // R16
    end
  end

  // ----------------------------------------
  // Offset correction, updated only on complete descriptor
  // ----------------------------------------
  logic ok_d1_q;
  logic [TOD_DELAY_W-1:0] fwd_app, ret_app;
  assign fwd_app = (fhit && i_ref_present) ? fdly : '0; // R8 R11 R12
  assign ret_app = rhit ? rdly : '0; // R13

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ok_d1_q      <= 1'b0;
      o_corr_valid <= 1'b0;
      o_corr       <= '0; // R15
      o_fwd_delay  <= '0;
      o_ret_delay  <= '0;
    end else begin
      ok_d1_q <= ok_q;
      if (ok_q && !ok_d1_q) begin
        o_corr_valid <= 1'b1;
        o_fwd_delay  <= fwd_app;
        o_ret_delay  <= ret_app;
        o_corr       <= {1'b0, fwd_app} + {1'b0, ret_app}; // R14
      end
    end
  end

  // ----------------------------------------
  // Security message output stream
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sec_valid      <= 1'b0;
      o_sec_type_valid <= 1'b0;
      o_sec_last       <= 1'b0;
      o_sec_data       <= '0;
    end else begin
      o_sec_valid      <= body && state_q == TOD_SPAY; // R3
      o_sec_type_valid <= body && state_q == TOD_STYPE; // R2
      o_sec_last       <= body && is_sec(state_q) && endlen;
      if (b) o_sec_data <= i_in.data;
    end
  end

  // ----------------------------------------
  // Security truncation flag
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sec_abort <= 1'b0;
    end else begin
      o_sec_abort <= trunc && is_sec(state_q); // R16
    end
  end
endmodule

// [tod_parser_props.sv]
// Port checker for the descriptor parser
`timescale 1ns/1ps
module tod_parser_props
  import tod_pkg::*;
(
  input wire logic                  i_clk,
  input wire logic                  i_rst,
  input wire tod_byte_t             i_in,
  input wire logic                  o_sec_valid,
  input wire logic                  o_sec_type_valid,
  input wire logic                  o_sec_last,
  input wire logic [7:0]            o_sec_data,
  input wire logic                  o_sec_abort,
  input wire logic                  o_corr_valid,
  input wire logic [TOD_CORR_W-1:0] o_corr,
  input wire logic [TOD_DELAY_W-1:0] o_fwd_delay,
  input wire logic [TOD_DELAY_W-1:0] o_ret_delay
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_type_cause: assert property (o_sec_type_valid |-> $past(i_in.valid))
    else $error("type without byte");
  chk_pay_cause: assert property (o_sec_valid |-> $past(i_in.valid))
    else $error("payload without byte");
  chk_sec_data: assert property ((o_sec_valid || o_sec_type_valid) |-> o_sec_data == $past(i_in.data))
    else $error("security byte differs");
  chk_sec_excl: assert property (!(o_sec_valid && o_sec_type_valid))
    else $error("type and payload together");
  chk_last_pair: assert property (o_sec_last |-> (o_sec_valid || o_sec_type_valid))
    else $error("last without byte");
  chk_abort_first: assert property (o_sec_abort |-> $past(i_in.valid && i_in.first))
    else $error("abort without new tag");
  chk_corr_sum: assert property (o_corr == {1'b0, o_fwd_delay} + {1'b0, o_ret_delay})
    else $error("correction not sum");
  chk_valid_stay: assert property (o_corr_valid |=> o_corr_valid)
    else $error("valid dropped");
  chk_none_zero: assert property (!o_corr_valid |-> o_corr == 33'h0)
    else $error("correction without descriptor");
  chk_corr_cause: assert property ($changed(o_corr) |-> ($past(i_in.valid) || $past(i_in.valid, 2)))
    else $error("correction moved idle");
  cover property (o_sec_last);
  cover property ($rose(o_corr_valid));
  cover property (o_sec_abort);
endmodule
bind tod_parser tod_parser_props u_props (.i_clk(i_clk), .i_rst(i_rst), .i_in(i_in), .o_sec_valid(o_sec_valid),
  .o_sec_type_valid(o_sec_type_valid), .o_sec_last(o_sec_last), .o_sec_data(o_sec_data), .o_sec_abort(o_sec_abort),
  .o_corr_valid(o_corr_valid), .o_corr(o_corr), .o_fwd_delay(o_fwd_delay), .o_ret_delay(o_ret_delay));

// [tod_src.sv]
// Descriptor byte source in place of the section demultiplexer
`timescale 1ns/1ps
module tod_src
  import tod_pkg::*;
(
  input  wire logic i_clk,
  output tod_byte_t o_in
);
  initial o_in = '{1'b0, 1'b0, 1'b0, 8'h5a};
  // One byte every gap+1 cycles, idle gaps with changing data
  task automatic send(input logic [7:0] b[$], input bit full, input int gap);
    for (int i = 0; i < b.size(); i++) begin
      @(negedge i_clk);
      o_in = '{1'b1, i == 0, full && i == b.size() - 1, b[i]};
      repeat (gap) begin
        @(negedge i_clk);
        o_in = '{1'b0, 1'b0, 1'b0, ~o_in.data};
      end
    end
    @(negedge i_clk);
    o_in = '{1'b0, 1'b0, 1'b0, ~o_in.data};
  endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the descriptor parser
`timescale 1ns/1ps
module tb_top;
  import tod_pkg::*;
  logic i_clk, i_rst, i_ref_present, sv, stv, sl, sa, cv;
  tod_byte_t i_in;
  tod_pair_t i_fwd_sel, i_ret_sel;
  logic [7:0] sd;
  logic [TOD_CORR_W-1:0] o_corr, old;
  logic [TOD_DELAY_W-1:0] fd, rd, ef, er;
  logic [7:0] q[$], got[$], ex[$];
  int n_mismatch, n_tests, seed, n_last, len, n_abort;
  bit hf, hr;
  tod_src src (.i_clk(i_clk), .o_in(i_in));
  tod_parser dut (.i_clk(i_clk), .i_rst(i_rst), .i_in(i_in), .i_fwd_sel(i_fwd_sel), .i_ret_sel(i_ret_sel),
    .i_ref_present(i_ref_present), .o_sec_valid(sv), .o_sec_type_valid(stv), .o_sec_last(sl), .o_sec_data(sd),
    .o_sec_abort(sa), .o_corr_valid(cv), .o_corr(o_corr), .o_fwd_delay(fd), .o_ret_delay(rd));
  initial begin
    i_clk = 0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (stv === 1'b1 || sv === 1'b1) got.push_back(sd);
    if (sl === 1'b1) n_last++;
    if (sa === 1'b1) n_abort++;
  end
  task automatic check(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [32:0] exp_c(bit r);
    return (r && hf ? {1'b0, ef} : 33'h0) + (hr ? {1'b0, er} : 33'h0);
  endfunction
  task automatic add_ent(input bit fw, input bit fm, input bit z);
    tod_pair_t s;
    logic [31:0] d;
    s = fw ? i_fwd_sel : i_ret_sel;
    if (!fm && $random(seed) % 2) s.sat_id ^= 8'h01;
    if (!fm && $random(seed) % 2) s.peer_id ^= 8'h02;
    d = z ? 32'h0 : $random(seed);
    q.push_back(s.sat_id);
    q.push_back(s.peer_id);
    for (int k = 3; k >= 0; k--) q.push_back(d[8*k+:8]);
    if (fw && !hf && s == i_fwd_sel) {hf, ef} = {1'b1, d};
    if (!fw && !hr && s == i_ret_sel) {hr, er} = {1'b1, d};
  endtask
  task automatic build_ofs(input int nf, input int nr, input bit fm, input bit z);
    q = {TOD_TAG_OFS_DEF, 8'h00, 8'(nf)};
    {hf, hr} = 2'b00;
    for (int i = 0; i < nf; i++) add_ent(1, fm, z);
    q.push_back(8'(nr));
    for (int i = 0; i < nr; i++) add_ent(0, fm, z);
    q[1] = 8'(q.size() - 2);
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    seed = 32'ha356;
    {i_rst, i_ref_present} = 2'b10;
    i_fwd_sel = '{8'h11, 8'h22};
    i_ret_sel = '{8'h11, 8'h33};
    repeat (16) @(negedge i_clk);
    i_rst = 0;
    repeat (2) @(negedge i_clk);
    check(cv === 1'b0 && o_corr === 33'h0, "correction after reset");
    for (int t = 0; t < 14; t++) begin
      i_ref_present = t[0];
      build_ofs(t < 3 ? 1 : $random(seed) & 3, t < 3 ? 2 : $random(seed) & 3, t < 3, t == 2);
      src.send(q, 1, t % 3);
      repeat (3) @(negedge i_clk);
      check(cv === 1'b1 && o_corr === exp_c(t[0]), "offset correction");
      check(rd === (hr ? er : 32'h0), "return delay");
      check(fd === ((t[0] && hf) ? ef : 32'h0), "forward delay");
    end
    old = o_corr;
    build_ofs(2, 2, 1, 0);
    q = q[0:8];
    src.send(q, 0, 0);
    q = {8'h7e, 8'h1e};
    repeat (30) q.push_back($random(seed));
    src.send(q, 1, 0);
    for (int t = 0; t < 8; t++) begin
      {n_last, len} = {32'h0, t == 0 ? 32'h1 : 32'h1 + ($random(seed) & 7)};
      got.delete();
      q = {TOD_TAG_SEC_DEF, 8'(len)};
      repeat (len) q.push_back($random(seed));
      ex = q[2:$];
      if (t[0]) q.push_back($random(seed));
      src.send(q, 1, t % 2);
      repeat (3) @(negedge i_clk);
      check(got == ex && n_last == 1, "security stream");
    end
    {n_abort, n_last} = 64'h0;
    got.delete();
    q = {TOD_TAG_SEC_DEF, 8'h05, 8'h3c, 8'h4d};
    src.send(q, 0, 0);
    q = {TOD_TAG_SEC_DEF, 8'h01, 8'h77};
    src.send(q, 1, 0);
    repeat (3) @(negedge i_clk);
    ex = {8'h3c, 8'h4d, 8'h77};
    check(n_abort == 1 && n_last == 1 && got == ex, "security abort");
    check(o_corr === old, "truncated offsets kept");
    finish_test();
  end
endmodule
